/* logic/housekeeping_cfg.svh */
// constants for the reset, timer and clock housekeeping block
`ifndef HOUSEKEEPING_CFG_SVH
`define HOUSEKEEPING_CFG_SVH

`define CLK_HZ            50000000.0
`define T_RESET_MS        0.65
`define T_RESET_MIN_MS    0.24
`define T_RESET_MAX_MS    1.0

`define OFF_CMD           8'h00
`define OFF_WAKEUP        8'h04
`define OFF_POWER_SETUP   8'h08
`define OFF_CLK_CFG       8'h0C
`define OFF_IRQ_STATUS    8'h10
`define OFF_IRQ_CLEAR     8'h14
`define OFF_IRQ_ENABLE    8'h18
`define OFF_STATUS        8'h1C
`define OFF_GEN_TIMER     8'h20

`define CMD_PREFIX        8'h80
`define CMD_SOFT_RESET    8'h70
`define CMD_WAKEUP_RELOAD 8'h68

`define POS_RATIO         0
`define POS_RM_SEL        15
`define POS_TUNE          16
`define POS_LOOP_BW       17
`define POS_DIV2_EN       0
`define POS_REF_HALVE     1
`define POS_LB_EN         2
`define POS_BO_EN         3

`define IRQ_WAKEUP        0
`define IRQ_GEN_TIMER     1
`define IRQ_LOW_BATT      2
`define IRQ_BROWNOUT      3

`define RST_WAKEUP_PRE    8'h01
`define RST_WAKEUP_CNT    8'h01
`define RST_RATIO         15'h0000
`define RST_DIV2_EN       1'b1

`endif

/* logic/housekeeping_pkg.sv */
// types shared by the housekeeping block and its timer
package housekeeping_pkg;

   typedef enum logic [0:0] {RST_HOLD, RST_RUN} rst_state_t;

   typedef struct packed {
      logic [8:0] pre;
      logic [8:0] cnt;
      logic       expired;
   } timer_state_t;

   // field order follows the bus image so a packed cast lines up with the byte lanes
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] prescale;
   } timer_cfg_t;

   typedef struct packed {
      logic        loop_bw;
      logic        tune;
      logic        rm_sel;
      logic [14:0] ratio;
   } power_cfg_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      rst_state_t  rst_st;
      logic [15:0] rst_cnt;
      logic        supply_q;
      logic        sdn_q;
      timer_cfg_t  wake;
      timer_cfg_t  gen;
      power_cfg_t  pwr;
      logic        div2_en;
      logic        ref_halve;
      logic        lb_en;
      logic        bo_en;
      logic [3:0]  irq_status;
      logic [3:0]  irq_en;
      logic        lb_q;
      logic        bo_q;
      logic [14:0] acc;
      logic [1:0]  div4;
      logic        reg_clk;
      logic        ref_ph;
      logic        ref_out;
   } hk_state_t;

endpackage : housekeeping_pkg

/* logic/prog_timer.sv */
// prescaler and counter timer with optional plus-one counting
`timescale 1ns/10ps
module prog_timer
   import housekeeping_pkg::*;
#(
   parameter int  VAL_W    = 8,
   parameter bit  PLUS_ONE = 1'b0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             tick_i,
   input  wire logic             reload_i,
   input  wire logic [VAL_W-1:0] prescale_i,
   input  wire logic [VAL_W-1:0] count_i,
   output logic                  expired_o
);
   if (VAL_W != 8) begin : g_chk
      $error("prog_timer serves 8-bit prescale and count only");
   end

   timer_state_t q;
   timer_state_t next_q;
   logic [8:0]   pre_lim;
   logic [8:0]   cnt_lim;
   logic         never;

   always_comb begin
      pre_lim = {1'b0, prescale_i} + (PLUS_ONE ? 9'h001 : 9'h000);
      cnt_lim = {1'b0, count_i} + (PLUS_ONE ? 9'h001 : 9'h000);
      // plus-one counting can never reach zero limits; without plus-one a zero byte stops the timer counting
      never = !PLUS_ONE && (prescale_i == 8'h00 || count_i == 8'h00);
      next_q = q;
      next_q.expired = 1'b0;
      if (reload_i) begin
         next_q.pre = 9'h000;
         next_q.cnt = 9'h000;
      end else if (tick_i && !never) begin
         if (q.pre + 9'h001 >= pre_lim) begin
            next_q.pre = 9'h000;
            if (q.cnt + 9'h001 >= cnt_lim) begin
               next_q.cnt     = 9'h000;
               next_q.expired = 1'b1;
            end else begin
               next_q.cnt = q.cnt + 9'h001;
            end
         end else begin
            next_q.pre = q.pre + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign expired_o = q.expired;

   property p_never_expires;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!PLUS_ONE && ($past(prescale_i) == 8'h00 || $past(count_i) == 8'h00)) |-> !expired_o;
   endproperty
   a_never_expires: assert property (p_never_expires) else $error("timer expired with a zero byte");

endmodule : prog_timer

/* logic/housekeeping.sv */
// reset generator, timers, regulator clock, dividers and battery warnings behind wishbone
`timescale 1ns/10ps
`include "housekeeping_cfg.svh"
module housekeeping
   import housekeeping_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = int'(`T_RESET_MS * `CLK_HZ / 1000.0)
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        supply_ok_i,
   input  wire logic        shutdown_pin_i,
   input  wire logic        rc_osc_tick_i,
   input  wire logic        ref_tick_i,
   input  wire logic        low_batt_i,
   input  wire logic        brownout_i,
   output logic             internal_reset_n_o,
   output logic             regulator_clk_o,
   output logic             regulator_tune_sel_o,
   output logic             regulator_loop_bw_sel_o,
   output logic             dig_div2_en_o,
   output logic             ref_clk_o,
   output logic             wakeup_o,
   output logic             low_batt_warn_o,
   output logic             irq_o
);
   localparam int unsigned RESET_MIN = int'(`T_RESET_MIN_MS * `CLK_HZ / 1000.0 + 0.999);
   localparam int unsigned RESET_MAX = int'(`T_RESET_MAX_MS * `CLK_HZ / 1000.0 - 0.5);
   localparam logic [15:0] RESET_LAST = 16'(RESET_CYCLES - 1);

   if (RESET_CYCLES < 2 || RESET_CYCLES > 65536) begin : g_chk
      $error("RESET_CYCLES must lie between 2 and 65536");
   end

   hk_state_t q;
   hk_state_t next_q;
   logic      acc_wr;
   logic      wr_cmd;
   logic      soft_reset_cmd;
   logic      wake_reload_cmd;
   logic      rst_start;
   logic      in_reset;
   logic      wake_expired;
   logic      gen_expired;
   logic [15:0] acc_sum;
   logic [3:0]  irq_set;
   logic [3:0]  irq_clr;
   logic [31:0] rd;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   function automatic logic is_cmd(input logic [31:0] d, input logic [3:0] sel, input logic [7:0] code);
      return (sel[1:0] == 2'b11) && (d[15:8] == `CMD_PREFIX) && (d[7:0] == code);
   endfunction : is_cmd

   // one access per strobe; ack drops the cycle after it rises
   assign acc_wr = wb_cyc_i && wb_stb_i && !q.ack && wb_we_i;
   assign wr_cmd = acc_wr && (wb_adr_i == `OFF_CMD);
   assign soft_reset_cmd  = wr_cmd && is_cmd(wb_dat_i, wb_sel_i, `CMD_SOFT_RESET);
   assign wake_reload_cmd = wr_cmd && is_cmd(wb_dat_i, wb_sel_i, `CMD_WAKEUP_RELOAD);
   assign in_reset = (q.rst_st == RST_HOLD);

   // rc ticks are the wake-up source; about 29 us each
   prog_timer #(
      .VAL_W    (8),
      .PLUS_ONE (1'b1)
   ) u_wakeup (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .tick_i     (rc_osc_tick_i),
      .reload_i   (in_reset || wake_reload_cmd),
      .prescale_i (q.wake.prescale),
      .count_i    (q.wake.count),
      .expired_o  (wake_expired)
   );

   prog_timer #(
      .VAL_W    (8),
      .PLUS_ONE (1'b0)
   ) u_gen (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .tick_i     (1'b1),
      .reload_i   (in_reset),
      .prescale_i (q.gen.prescale),
      .count_i    (q.gen.count),
      .expired_o  (gen_expired)
   );

   always_comb begin
      rst_start = (supply_ok_i && !q.supply_q && !shutdown_pin_i)
               || (!shutdown_pin_i && q.sdn_q && supply_ok_i)
               || soft_reset_cmd;
      acc_sum = {1'b0, q.acc} + {1'b0, q.pwr.ratio};
      irq_set = '0;
      irq_set[`IRQ_WAKEUP]    = wake_expired;
      irq_set[`IRQ_GEN_TIMER] = gen_expired;
      irq_set[`IRQ_LOW_BATT]  = q.lb_en && low_batt_i && !q.lb_q;
      irq_set[`IRQ_BROWNOUT]  = q.bo_en && brownout_i && !q.bo_q;
      irq_clr = '0;
      if (acc_wr && wb_adr_i == `OFF_IRQ_CLEAR) begin
         irq_clr = wb_dat_i[3:0] & {4{wb_sel_i[0]}};
      end

      rd = 32'h0000_0000;
      if (wb_adr_i == `OFF_WAKEUP) begin
         rd[15:0] = {q.wake.count, q.wake.prescale};
      end else if (wb_adr_i == `OFF_POWER_SETUP) begin
         rd[`POS_LOOP_BW:0] = {q.pwr.loop_bw, q.pwr.tune, q.pwr.rm_sel, q.pwr.ratio};
      end else if (wb_adr_i == `OFF_CLK_CFG) begin
         rd[3:0] = {q.bo_en, q.lb_en, q.ref_halve, q.div2_en};
      end else if (wb_adr_i == `OFF_IRQ_STATUS) begin
         rd[3:0] = q.irq_status;
      end else if (wb_adr_i == `OFF_IRQ_ENABLE) begin
         rd[3:0] = q.irq_en;
      end else if (wb_adr_i == `OFF_STATUS) begin
         rd[3:0] = {brownout_i, low_batt_i, shutdown_pin_i, supply_ok_i};
      end else if (wb_adr_i == `OFF_GEN_TIMER) begin
         rd[15:0] = {q.gen.count, q.gen.prescale};
      end

      next_q = q;
      next_q.ack      = wb_cyc_i && wb_stb_i && !q.ack;
      next_q.rdata    = (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i) ? rd : q.rdata;
      next_q.supply_q = supply_ok_i;
      next_q.sdn_q    = shutdown_pin_i;
      next_q.lb_q     = low_batt_i;
      next_q.bo_q     = brownout_i;

      // the reset generator itself is never cleared by the reset it makes
      if (!supply_ok_i || shutdown_pin_i || rst_start) begin
         next_q.rst_st  = RST_HOLD;
         next_q.rst_cnt = 16'h0000;
      end else if (q.rst_st == RST_HOLD) begin
         if (q.rst_cnt == RESET_LAST) begin
            next_q.rst_st = RST_RUN;
         end else begin
            next_q.rst_cnt = q.rst_cnt + 16'h0001;
         end
      end

      if (acc_wr && !in_reset) begin
         if (wb_adr_i == `OFF_WAKEUP) begin
            next_q.wake = timer_cfg_t'(16'(merge_bytes({16'h0000, q.wake}, wb_dat_i, wb_sel_i)));
         end else if (wb_adr_i == `OFF_GEN_TIMER) begin
            next_q.gen = timer_cfg_t'(16'(merge_bytes({16'h0000, q.gen}, wb_dat_i, wb_sel_i)));
         end else if (wb_adr_i == `OFF_POWER_SETUP) begin
            next_q.pwr = power_cfg_t'(18'(merge_bytes({14'h0000, q.pwr}, wb_dat_i, wb_sel_i)));
         end else if (wb_adr_i == `OFF_CLK_CFG && wb_sel_i[0]) begin
            next_q.div2_en   = wb_dat_i[`POS_DIV2_EN];
            next_q.ref_halve = wb_dat_i[`POS_REF_HALVE];
            next_q.lb_en     = wb_dat_i[`POS_LB_EN];
            next_q.bo_en     = wb_dat_i[`POS_BO_EN];
         end else if (wb_adr_i == `OFF_IRQ_ENABLE && wb_sel_i[0]) begin
            next_q.irq_en = wb_dat_i[3:0];
         end
      end

      // a new event beats a clear landing in the same cycle
      next_q.irq_status = (q.irq_status & ~irq_clr) | irq_set;

      // rate multiplier overflows at ratio/2^15 of the clock; divide-by-four is a square wave
      next_q.div4 = q.div4 + 2'b01;
      next_q.acc  = acc_sum[14:0];
      next_q.reg_clk = q.pwr.rm_sel ? acc_sum[15] : q.div4[1];

      if (ref_tick_i) begin
         next_q.ref_ph = !q.ref_ph;
      end
      next_q.ref_out = ref_tick_i && (!q.ref_halve || q.ref_ph);

      if (in_reset) begin
         next_q.wake.prescale = `RST_WAKEUP_PRE;
         next_q.wake.count    = `RST_WAKEUP_CNT;
         next_q.gen           = '0;
         next_q.pwr           = '{ratio: `RST_RATIO, rm_sel: 1'b0, tune: 1'b0, loop_bw: 1'b0};
         next_q.div2_en       = `RST_DIV2_EN;
         next_q.ref_halve     = 1'b0;
         next_q.lb_en         = 1'b0;
         next_q.bo_en         = 1'b0;
         next_q.irq_status    = '0;
         next_q.irq_en        = '0;
         next_q.acc           = '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q            <= '0;
         q.rst_st     <= RST_HOLD;
         q.wake       <= '{prescale: `RST_WAKEUP_PRE, count: `RST_WAKEUP_CNT};
         q.div2_en    <= `RST_DIV2_EN;
      end else begin
         q <= next_q;
      end
   end

   assign wb_ack_o                = q.ack;
   assign wb_dat_o                = q.rdata;
   assign internal_reset_n_o      = (q.rst_st == RST_RUN);
   assign regulator_clk_o         = q.reg_clk;
   assign regulator_tune_sel_o    = q.pwr.tune;
   assign regulator_loop_bw_sel_o = q.pwr.loop_bw;
   assign dig_div2_en_o           = q.div2_en;
   assign ref_clk_o               = q.ref_out;
   assign wakeup_o                = q.irq_status[`IRQ_WAKEUP] && !in_reset;
   assign low_batt_warn_o         = (q.lb_en && low_batt_i) || (q.bo_en && brownout_i);
   assign irq_o                   = |(q.irq_status & q.irq_en);

   property p_reset_width;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(internal_reset_n_o) |-> $past(q.rst_cnt) == RESET_LAST;
   endproperty
   a_reset_width: assert property (p_reset_width) else $error("reset released early or late");

   property p_sdn_step;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!shutdown_pin_i && q.sdn_q && supply_ok_i) |=> !internal_reset_n_o ##1 !internal_reset_n_o;
   endproperty
   a_sdn_step: assert property (p_sdn_step) else $error("shutdown step gave no reset");

   property p_defaults;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!internal_reset_n_o && !$past(internal_reset_n_o)) |-> (q.irq_en == 4'h0 && !q.pwr.rm_sel
         && q.div2_en && q.wake.prescale == `RST_WAKEUP_PRE && q.irq_status == 4'h0);
   endproperty
   a_defaults: assert property (p_defaults) else $error("register not at default during reset");

   property p_soft_reset;
      @(posedge clk_i) disable iff (!rst_n_i)
      soft_reset_cmd |=> !internal_reset_n_o[*2];
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset command ignored");

   property p_div4;
      @(posedge clk_i) disable iff (!rst_n_i)
      // the two samples before the edge must also come from the divider, not a last carry pulse
      ($rose(regulator_clk_o) && !q.pwr.rm_sel && !$past(q.pwr.rm_sel) && !$past(q.pwr.rm_sel, 2)
         ##1 !q.pwr.rm_sel) |-> regulator_clk_o ##1 !regulator_clk_o;
   endproperty
   a_div4: assert property (p_div4) else $error("divide-by-four output wrong");

   property p_ratio_zero;
      @(posedge clk_i) disable iff (!rst_n_i)
      (q.pwr.rm_sel && q.pwr.ratio == 15'h0000) |=> !regulator_clk_o;
   endproperty
   a_ratio_zero: assert property (p_ratio_zero) else $error("rate multiplier pulsed at zero ratio");

   property p_no_warn_reset;
      @(posedge clk_i) disable iff (!rst_n_i)
      (internal_reset_n_o && supply_ok_i && !shutdown_pin_i && !soft_reset_cmd) |=> internal_reset_n_o;
   endproperty
   a_no_warn_reset: assert property (p_no_warn_reset) else $error("warning path reset the device");

   property p_wake_event;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wake_expired && internal_reset_n_o) |=> q.irq_status[`IRQ_WAKEUP];
   endproperty
   a_wake_event: assert property (p_wake_event) else $error("wake-up expiry lost");

   property p_ref_halve;
      @(posedge clk_i) disable iff (!rst_n_i)
      (q.ref_halve && ref_tick_i && !q.ref_ph) |=> !ref_clk_o;
   endproperty
   a_ref_halve: assert property (p_ref_halve) else $error("reference not halved");

endmodule : housekeeping

/* bench/analog_env.sv */
// far-side source model: rc oscillator and reference tick pulses
`timescale 1ns/10ps
module analog_env #(
   parameter int RC_DIV  = 3,
   parameter int REF_DIV = 5
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      rc_osc_tick_o,
   output logic      ref_tick_o
);
   int rc_n;
   int ref_n;

   // one-cycle pulses at a fixed rate so that every period is an exact cycle count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rc_n          <= 0;
         ref_n         <= 0;
         rc_osc_tick_o <= 1'b0;
         ref_tick_o    <= 1'b0;
      end else begin
         rc_n          <= (rc_n == RC_DIV - 1) ? 0 : rc_n + 1;
         ref_n         <= (ref_n == REF_DIV - 1) ? 0 : ref_n + 1;
         rc_osc_tick_o <= (rc_n == RC_DIV - 1);
         ref_tick_o    <= (ref_n == REF_DIV - 1);
      end
   end
endmodule : analog_env

/* bench/housekeeping_tb.sv */
// self-checking bench for the housekeeping block
`timescale 1ns/10ps
`include "housekeeping_cfg.svh"
module housekeeping_tb;
   localparam int RST_N   = 8;
   localparam int RC_DIV  = 3;
   localparam int REF_DIV = 5;
   logic        clk_i     = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic        cyc       = 1'b0;
   logic        stb       = 1'b0;
   logic        we        = 1'b0;
   logic [7:0]  adr       = 8'h00;
   logic [3:0]  sel       = 4'h0;
   logic [31:0] dat       = 32'h0;
   logic        supply_ok = 1'b1;
   logic        shutdown_pin       = 1'b0;
   logic        low_batt  = 1'b0;
   logic        brownout  = 1'b0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        ack, rc_tick, ref_tick, irst_n, reg_clk, tune, loop_bw, div2, ref_clk, wakeup, warn, irq;
   int          error_cnt = 0;
   int          n_tests   = 0;
   int          now       = 0;
   int          n;

   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) now <= now + 1;

   housekeeping #(.RESET_CYCLES(RST_N)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .supply_ok_i(supply_ok), .shutdown_pin_i(shutdown_pin), .rc_osc_tick_i(rc_tick), .ref_tick_i(ref_tick),
      .low_batt_i(low_batt), .brownout_i(brownout), .internal_reset_n_o(irst_n), .regulator_clk_o(reg_clk),
      .regulator_tune_sel_o(tune), .regulator_loop_bw_sel_o(loop_bw), .dig_div2_en_o(div2),
      .ref_clk_o(ref_clk), .wakeup_o(wakeup), .low_batt_warn_o(warn), .irq_o(irq));

   analog_env #(.RC_DIV(RC_DIV), .REF_DIV(REF_DIV)) env (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .rc_osc_tick_o(rc_tick), .ref_tick_o(ref_tick));

   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_reg

   task automatic chk_pin(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk_pin

   // entered just after a rising edge; leaves one edge after the released cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
      chk_pin("bus ack", 1'b1, k < 50);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, q);
      chk_reg($sformatf("register %h", a), exp, q);
   endtask : rd

   task automatic wait_ready(output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (irst_n !== 1'b1 && k < 100);
   endtask : wait_ready

   task automatic wait_irq();
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (irq !== 1'b1 && n < 200);
   endtask : wait_irq

   // spacing of two successive events, cleared in between so the second one shows
   task automatic period(input int b, input int exp);
      int t0;
      wr(`OFF_IRQ_ENABLE, 32'h1 << b);
      wr(`OFF_IRQ_CLEAR, 32'hF);
      wait_irq();
      t0 = now;
      wr(`OFF_IRQ_CLEAR, 32'h1 << b);
      wait_irq();
      chk_reg($sformatf("period of event %0d", b), 32'(exp), 32'(now - t0));
   endtask : period

   task automatic count_hi(input bit use_ref, input int cycles, output int k);
      k = 0;
      repeat (cycles) begin
         @(posedge clk_i);
         k += ((use_ref ? ref_clk : reg_clk) === 1'b1);
      end
   endtask : count_hi

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (8000) @(posedge clk_i);
      error_cnt++;
      $display("unexpected run length: expected end seen watchdog");
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      chk_pin("reset during rst_n", 1'b0, irst_n);
      rst_n_i <= 1'b1;
      wait_ready(n);
      chk_pin("power-up reset width", 1'b1, n >= RST_N - 1 && n <= RST_N + 4);
      rd(`OFF_WAKEUP, 32'h0000_0101);
      rd(`OFF_GEN_TIMER, 32'h0);
      rd(`OFF_POWER_SETUP, 32'h0);
      rd(`OFF_CLK_CFG, 32'h1);
      chk_pin("div2 default", 1'b1, div2);
      rd(`OFF_STATUS, 32'h1);
      wr(8'h3C, 32'hFFFF_FFFF);
      rd(8'h3C, 32'h0);
      $display("test defaults done");

      count_hi(1'b0, 40, n);
      chk_reg("divide-by-four highs", 32'd20, 32'(n));
      wr(`OFF_POWER_SETUP, 32'h0001_9000);
      count_hi(1'b0, 40, n);
      chk_reg("rate multiplier pulses", 32'd5, 32'(n));
      chk_pin("tune select", 1'b1, tune);
      chk_pin("loop bandwidth select", 1'b0, loop_bw);
      wr(`OFF_POWER_SETUP, 32'h0002_8000);
      count_hi(1'b0, 40, n);
      chk_reg("zero ratio pulses", 32'd0, 32'(n));
      chk_pin("loop bandwidth high", 1'b1, loop_bw);
      count_hi(1'b1, 100, n);
      chk_reg("reference pulses", 32'(100 / REF_DIV), 32'(n));
      wr(`OFF_CLK_CFG, 32'h3);
      count_hi(1'b1, 100, n);
      chk_reg("halved reference pulses", 32'(100 / REF_DIV / 2), 32'(n));
      $display("test clocks done");

      wr(`OFF_GEN_TIMER, 32'h0000_0403);
      period(1, 12);
      for (int i = 0; i < 2; i++) begin
         wr(`OFF_GEN_TIMER, i ? 32'h0000_0003 : 32'h0000_0400);
         wr(`OFF_IRQ_CLEAR, 32'hF);
         repeat (40) @(posedge clk_i);
         bus(1'b0, `OFF_IRQ_STATUS, 32'h0, q);
         chk_pin("zero timer event", 1'b0, q[1]);
      end
      for (int i = 0; i < 2; i++) begin
         wr(`OFF_WAKEUP, i ? 32'h0000_0102 : 32'h0000_0101);
         wr(`OFF_CMD, 32'h0000_8068);
         period(0, i ? 6 * RC_DIV : 4 * RC_DIV);
         chk_pin("wake-up level", 1'b1, wakeup);
      end
      $display("test timers done");

      // a long wake-up period keeps bit 0 out of the status read below
      wr(`OFF_WAKEUP, 32'h0000_FFFF);
      wr(`OFF_CMD, 32'h0000_8068);
      wr(`OFF_CLK_CFG, 32'hD);
      wr(`OFF_IRQ_CLEAR, 32'hF);
      wr(`OFF_IRQ_ENABLE, 32'hC);
      low_batt <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_pin("low battery warning", 1'b1, warn);
      chk_pin("battery interrupt", 1'b1, irq);
      low_batt <= 1'b0;
      brownout <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_pin("brownout warning", 1'b1, warn);
      chk_pin("no reset on warning", 1'b1, irst_n);
      brownout <= 1'b0;
      rd(`OFF_IRQ_STATUS, 32'hC);
      wr(`OFF_CLK_CFG, 32'h1);
      low_batt <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_pin("disabled warning", 1'b0, warn);
      low_batt <= 1'b0;
      $display("test battery done");

      wr(`OFF_CLK_CFG, 32'h0);
      chk_pin("div2 cleared", 1'b0, div2);
      wr(`OFF_CMD, 32'h0000_0070);
      chk_pin("no reset on bad prefix", 1'b1, irst_n);
      wr(`OFF_CMD, 32'h0000_8070);
      chk_pin("soft reset active", 1'b0, irst_n);
      wr(`OFF_WAKEUP, 32'h0000_0505);
      wait_ready(n);
      chk_pin("soft reset ends", 1'b1, n <= RST_N + 4);
      // status first: the default wake-up period sets bit 0 soon after release
      rd(`OFF_IRQ_STATUS, 32'h0);
      rd(`OFF_CLK_CFG, 32'h1);
      rd(`OFF_POWER_SETUP, 32'h0);
      rd(`OFF_WAKEUP, 32'h0000_0101);
      chk_pin("div2 after reset", 1'b1, div2);
      $display("test soft reset done");

      shutdown_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk_pin("shutdown holds reset", 1'b0, irst_n);
      shutdown_pin <= 1'b0;
      wait_ready(n);
      chk_pin("shutdown step width", 1'b1, n >= RST_N - 1 && n <= RST_N + 4);
      $display("test shutdown done");
      tally_and_finish();
   end
endmodule : housekeeping_tb
